// >>> testbench/camd_tb.sv
// directed self-checking bench for the arithmetic core
`timescale 1ns/1ps
module testbench;
  // single-bit controls and flags
  logic ref_clk, reset, b_from_mem, dst_to_mem, alu_valid, alu_byte;
  logic mul_valid, div_start, div_signed, div_wide, dsp_valid;
  logic dsp_acc_b, dsp_wb, frac_mode_select, round_mode_select;
  logic acc_a_saturate, acc_b_saturate, memory_write_saturate;
  logic saturation_width_select, div_busy, mem_we, mem_byte;
  // operand and result buses
  logic [3:0]  src_a_sel, src_b_sel, dst_sel;
  logic [15:0] mem_rdata, dsp_x, dsp_y, alu_result, quotient_reg;
  logic [15:0] remainder_reg, mem_wdata;
  logic [4:0]  mul_lit, status_reg;
  logic [1:0]  sign_mode_select;
  logic [31:0] mul_result;
  logic [39:0] accumulator_a, accumulator_b;
  camd_pkg::camd_alu_op_e   alu_op;
  camd_pkg::camd_mul_mode_e mul_mode;
  camd_pkg::camd_dsp_op_e   dsp_op;
  int failures, comparisons, cyc, n;
  // products of ffff by ffff (literal 3) in enum order
  logic [31:0] mexp [7] = '{32'h00000001, 32'hFFFE0001, 32'hFFFF0001,
    32'hFFFF0001, 32'hFFFFFFFD, 32'h0002FFFD, 32'h0000FE01};
  camd_core dut_u (.*);
  // 8 ns period
  always #4 ref_clk = ~ref_clk;
  task summarize();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, far above the roughly 140 cycles needed
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      summarize();
    end
  end
  task chk(input logic [39:0] g, e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // an idle edge, then one edge takes the request; pulses drop after it
  task go(input logic [3:0] p);
    @(posedge ref_clk);
    #1;
    {alu_valid, mul_valid, div_start, dsp_valid} = p;
    @(posedge ref_clk);
    #1;
    {alu_valid, mul_valid, div_start, dsp_valid} = 4'h0;
  endtask
  task alu(input camd_pkg::camd_alu_op_e op, input logic [3:0] a, d,
           input logic bm, input logic [15:0] m, input logic byt);
    src_a_sel = a;
    src_b_sel = a;
    b_from_mem = bm;
    mem_rdata = m;
    dst_sel = d;
    alu_op = op;
    alu_byte = byt;
    go(4'h8);
  endtask
  // divisor always in register 5; second start while busy must be dropped
  task dv(input logic [3:0] a, input logic s, w, input logic [15:0] q, r);
    src_a_sel = a;
    src_b_sel = 4'h5;
    div_signed = s;
    div_wide = w;
    go(4'h2);
    chk(div_busy, 40'h1);
    src_b_sel = 4'hF;
    go(4'h2);
    n = 3;
    while (div_busy && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(40'(n), 40'h12);
    chk(quotient_reg, q);
    chk(remainder_reg, r);
  endtask
  task dsp(input camd_pkg::camd_dsp_op_e op, input logic [15:0] x, y,
           input logic b, wb);
    dsp_op = op;
    dsp_x = x;
    dsp_y = y;
    dsp_acc_b = b;
    dsp_wb = wb;
    go(4'h1);
  endtask
  initial begin
    {ref_clk, b_from_mem, dst_to_mem, alu_valid, alu_byte, mul_valid,
     div_start, div_signed, div_wide, dsp_valid, dsp_acc_b, dsp_wb,
     frac_mode_select, round_mode_select, acc_a_saturate, acc_b_saturate,
     memory_write_saturate, saturation_width_select} = 18'h0;
    {src_a_sel, src_b_sel, dst_sel, mem_rdata, dsp_x, dsp_y} = 60'h0;
    {mul_lit, sign_mode_select} = 7'h0;
    alu_op = camd_pkg::CAMD_ADD;
    mul_mode = camd_pkg::CAMD_M_SS;
    dsp_op = camd_pkg::CAMD_CLR;
    reset = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    // register 15 is never written, so it reads zero for loads
    alu(camd_pkg::CAMD_ADD, 4'hF, 4'h2, 1, 16'h7FFF, 0);
    alu(camd_pkg::CAMD_ADD, 4'h2, 4'hA, 1, 16'h0001, 0);
    chk(alu_result, 40'h8000);
    chk(status_reg, 40'h1C);
    alu(camd_pkg::CAMD_SHL, 4'hA, 4'hB, 0, 16'h0000, 0);
    chk(status_reg, 40'h17);
    alu(camd_pkg::CAMD_ASR, 4'hA, 4'hB, 0, 16'h0000, 0);
    chk(alu_result, 40'hC000);
    alu(camd_pkg::CAMD_IOR, 4'h2, 4'hB, 1, 16'h8000, 0);
    chk(alu_result, 40'hFFFF);
    alu(camd_pkg::CAMD_SUB, 4'hF, 4'hA, 1, 16'h0001, 0);
    chk(status_reg, 40'h08);
    alu(camd_pkg::CAMD_SUB, 4'h2, 4'hA, 0, 16'h0000, 0);
    chk(status_reg, 40'h13);
    alu(camd_pkg::CAMD_ADD, 4'h2, 4'hA, 1, 16'h0001, 1);
    chk(alu_result, 40'h0);
    dst_to_mem = 1'b1;
    alu(camd_pkg::CAMD_ADD, 4'hF, 4'hA, 1, 16'h1234, 0);
    chk({mem_we, mem_byte, mem_wdata}, 40'h21234);
    dst_to_mem = 1'b0;
    $display("alu test done");
    alu(camd_pkg::CAMD_ADD, 4'hF, 4'h4, 1, 16'hFFFF, 0);
    // a from register 4, b from memory, both ffff
    {mul_lit, dst_sel, src_a_sel} = {5'h03, 4'h8, 4'h4};
    for (int i = 0; i < 7; i++) begin
      mul_mode = camd_pkg::camd_mul_mode_e'(i);
      go(4'h4);
      chk(mul_result, mexp[i]);
    end
    $display("multiply test done");
    alu(camd_pkg::CAMD_ADD, 4'hF, 4'h5, 1, 16'h0002, 0);
    alu(camd_pkg::CAMD_ADD, 4'hF, 4'h6, 1, 16'hFFF9, 0);
    alu(camd_pkg::CAMD_ADD, 4'hF, 4'h7, 1, 16'h0001, 0);
    dv(4'h6, 1, 0, 16'hFFFD, 16'hFFFF);
    dv(4'h7, 0, 1, 16'hFFFC, 16'h0001);
    dv(4'h6, 0, 0, 16'h7FFC, 16'h0001);
    $display("divide test done");
    frac_mode_select = 1'b1;
    dsp(camd_pkg::CAMD_MPY, 16'h4000, 16'h4000, 0, 0);
    chk(accumulator_a, 40'h0020000000);
    dsp(camd_pkg::CAMD_CLR, 16'h0, 16'h0, 1, 1);
    chk({mem_we, mem_wdata}, 40'h12000);
    frac_mode_select = 1'b0;
    acc_a_saturate = 1'b1;
    dsp(camd_pkg::CAMD_MPY, 16'h7FFF, 16'h7FFF, 0, 0);
    dsp(camd_pkg::CAMD_MAC, 16'h7FFF, 16'h7FFF, 0, 0);
    dsp(camd_pkg::CAMD_MAC, 16'h7FFF, 16'h7FFF, 0, 0);
    chk(accumulator_a, 40'h007FFFFFFF);
    dsp(camd_pkg::CAMD_NEGA, 16'h0, 16'h0, 0, 0);
    chk(accumulator_a, 40'hFF80000001);
    saturation_width_select = 1'b1;
    dsp(camd_pkg::CAMD_MSC, 16'h7FFF, 16'h7FFF, 0, 0);
    chk(accumulator_a, 40'hFF40010000);
    sign_mode_select = 2'h1;
    dsp(camd_pkg::CAMD_MPY, 16'hFFFF, 16'hFFFF, 1, 0);
    chk(accumulator_b, 40'h00FFFE0001);
    memory_write_saturate = 1'b1;
    dsp(camd_pkg::CAMD_CLR, 16'h0, 16'h0, 0, 1);
    chk({mem_we, mem_wdata}, 40'h17FFF);
    sign_mode_select = 2'h2;
    dsp(camd_pkg::CAMD_MPY, 16'hFFFF, 16'hFFFF, 1, 0);
    chk(accumulator_b, 40'hFFFFFF0001);
    sign_mode_select = 2'h0;
    dsp(camd_pkg::CAMD_ED, 16'h0003, 16'h0001, 1, 0);
    chk(accumulator_b, 40'h0000000004);
    dsp(camd_pkg::CAMD_MPY, 16'h0080, 16'h0100, 1, 0);
    round_mode_select = 1'b1;
    dsp(camd_pkg::CAMD_CLR, 16'h0, 16'h0, 0, 1);
    chk({mem_we, mem_wdata}, 40'h10000);
    $display("dsp test done");
    summarize();
  end
endmodule

// >>> verilog/camd_core.sv
// alu, multiplier, divider and dsp engine of the core datapath
//
// How it works
// - 16-bit alu: add, sub, shifts, logic
// - operands and results are two's complement
// - alu updates c, z, n, ov, dc
// - subtract: carry and dc mean no borrow
// - byte or word width per instruction
// - operands from registers or memory, same destinations
// - 17x17 multiplier for all integer products
// - word modes ss, uu, su, us
// - word by 5-bit literal, byte by byte
// - signed/unsigned 32/16 and 16/16 divide
// - quotient to register 0, remainder register 1
// - any divisor register, even pair dividend
// - one cycle per divisor bit, always
// - dsp: multiplier, 40-bit adder, two accumulators
// - accumulator add, subtract and negate
// - fractional or integer dsp multiply
// - dsp multiply signed, unsigned or mixed
// - conventional or convergent rounding
// - saturation enable per accumulator
// - saturation enable for memory writes
// - saturation range select
// - dsp op set; limited other-accumulator write back
`timescale 1ns/1ps
module camd_core (
  // clock and reset
  input  logic                      ref_clk,
  input  logic                      reset,
  // operand routing
  input  logic [3:0]                src_a_sel,
  input  logic [3:0]                src_b_sel,
  input  logic                      b_from_mem,
  input  logic [15:0]               mem_rdata,
  input  logic [3:0]                dst_sel,
  input  logic                      dst_to_mem,
  // alu request
  input  logic                      alu_valid,
  input  camd_pkg::camd_alu_op_e    alu_op,
  input  logic                      alu_byte,
  // multiply request
  input  logic                      mul_valid,
  input  camd_pkg::camd_mul_mode_e  mul_mode,
  input  logic [4:0]                mul_lit,
  // divide request
  input  logic                      div_start,
  input  logic                      div_signed,
  input  logic                      div_wide,
  output logic                      div_busy,
  // dsp request
  input  logic                      dsp_valid,
  input  camd_pkg::camd_dsp_op_e    dsp_op,
  input  logic                      dsp_acc_b,
  input  logic [15:0]               dsp_x,
  input  logic [15:0]               dsp_y,
  input  logic                      dsp_wb,
  // core control bits
  input  logic                      frac_mode_select,
  input  logic [1:0]                sign_mode_select,
  input  logic                      round_mode_select,
  input  logic                      acc_a_saturate,
  input  logic                      acc_b_saturate,
  input  logic                      memory_write_saturate,
  input  logic                      saturation_width_select,
  // results
  output logic [15:0]               alu_result,
  output logic [4:0]                status_reg,
  output logic [31:0]               mul_result,
  output logic [15:0]               quotient_reg,
  output logic [15:0]               remainder_reg,
  output logic [39:0]               accumulator_a,
  output logic [39:0]               accumulator_b,
  output logic                      mem_we,
  output logic                      mem_byte,
  output logic [15:0]               mem_wdata
);
  logic [15:0] wreg_q [camd_pkg::WREG_N];  // working registers

  // clamp a 41-bit sum to the selected accumulator range
  function automatic logic [39:0] sat40(input logic [40:0] v,
                                        input logic en,
                                        input logic wide);
    logic hi;
    logic lo;
    hi = wide ? (!v[40] && v[39]) : (!v[40] && (v[39:31] != 9'h000));
    lo = wide ? (v[40] && !v[39]) : (v[40] && (v[39:31] != 9'h1FF));
    if (en && hi)
      return wide ? camd_pkg::SAT39_POS : camd_pkg::SAT31_POS;
    if (en && lo)
      return wide ? camd_pkg::SAT39_NEG : camd_pkg::SAT31_NEG;
    return v[39:0];
  endfunction

  // round an accumulator to a memory word, optionally clamped
  function automatic logic [15:0] acc_store(input logic [39:0] a,
                                            input logic conv,
                                            input logic sat);
    logic [39:0] r;
    r = a + camd_pkg::RND_HALF;
    // convergent: exact half rounds toward even
    if (conv && a[15:0] == 16'h8000 && !a[16])
      r = a;
    if (sat && r[39:31] != {9{r[39]}})
      return r[39] ? camd_pkg::MEM_NEG : camd_pkg::MEM_POS;
    return r[31:16];
  endfunction

  // ops that may write the other accumulator back
  function automatic logic wb_ok(input camd_pkg::camd_dsp_op_e op);
    return op == camd_pkg::CAMD_CLR || op == camd_pkg::CAMD_MAC ||
           op == camd_pkg::CAMD_PREF || op == camd_pkg::CAMD_MSC;
  endfunction

  logic [15:0] opa;
  logic [15:0] opb;
  assign opa = wreg_q[src_a_sel];
  assign opb = b_from_mem ? mem_rdata : wreg_q[src_b_sel];

  // alu datapath
  logic        is_sub;   // subtract selects inverted b plus one
  logic        is_arith; // add or subtract
  logic [15:0] bx;
  logic [16:0] sum17;
  logic [8:0]  sum9;
  logic [4:0]  sum5;     // nibble carry for dc
  logic [15:0] alu_r;
  logic        alu_c;
  logic        a_msb;
  logic        b_msb;
  logic        r_msb;
  logic [4:0]  st_d;
  logic [15:0] alu_q;
  logic [4:0]  status_q;

  assign is_sub   = (alu_op == camd_pkg::CAMD_SUB);
  assign is_arith = is_sub || (alu_op == camd_pkg::CAMD_ADD);
  assign bx    = is_sub ? ~opb : opb;
  assign sum17 = {1'b0, opa} + {1'b0, bx} + {16'h0000, is_sub};
  assign sum9  = {1'b0, opa[7:0]} + {1'b0, bx[7:0]} + {8'h00, is_sub};
  assign sum5  = {1'b0, opa[3:0]} + {1'b0, bx[3:0]} + {4'h0, is_sub};

  always_comb begin
    alu_r = sum17[15:0];
    alu_c = alu_byte ? sum9[8] : sum17[16];
    unique case (alu_op)
      camd_pkg::CAMD_ADD, camd_pkg::CAMD_SUB: begin
        alu_r = sum17[15:0];
      end
      camd_pkg::CAMD_AND: alu_r = opa & opb;
      camd_pkg::CAMD_IOR: alu_r = opa | opb;
      camd_pkg::CAMD_XOR: alu_r = opa ^ opb;
      camd_pkg::CAMD_SHL: begin
        alu_r = alu_byte ? {8'h00, opa[6:0], 1'b0} : {opa[14:0], 1'b0};
        alu_c = alu_byte ? opa[7] : opa[15];
      end
      camd_pkg::CAMD_LSR: begin
        alu_r = alu_byte ? {9'h000, opa[7:1]} : {1'b0, opa[15:1]};
        alu_c = opa[0];
      end
      camd_pkg::CAMD_ASR: begin
        alu_r = alu_byte ? {8'h00, opa[7], opa[7:1]}
                         : {opa[15], opa[15:1]};
        alu_c = opa[0];
      end
    endcase
  end

  assign a_msb = alu_byte ? opa[7] : opa[15];
  assign b_msb = alu_byte ? bx[7] : bx[15];
  assign r_msb = alu_byte ? alu_r[7] : alu_r[15];

  // flag update; logic ops leave c, ov, dc alone
  always_comb begin
    st_d = status_q;
    st_d[camd_pkg::ST_Z] = alu_byte ? (alu_r[7:0] == 8'h00)
                                    : (alu_r == 16'h0000);
    st_d[camd_pkg::ST_N] = r_msb;
    if (is_arith) begin
      // carry out of inverted add is the no-borrow flag
      st_d[camd_pkg::ST_C]  = alu_c;
      st_d[camd_pkg::ST_DC] = sum5[4];
      st_d[camd_pkg::ST_OV] = (a_msb == b_msb) && (r_msb != a_msb);
    end else if (alu_op == camd_pkg::CAMD_SHL ||
                 alu_op == camd_pkg::CAMD_LSR ||
                 alu_op == camd_pkg::CAMD_ASR) begin
      st_d[camd_pkg::ST_C] = alu_c;
    end
  end

  // alu result and status register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alu_q    <= 16'h0000;
      status_q <= camd_pkg::STATUS_RST;
    end else if (alu_valid) begin
      alu_q    <= alu_byte ? {8'h00, alu_r[7:0]} : alu_r;
      status_q <= st_d;
    end
  end
  assign alu_result = alu_q;
  assign status_reg = status_q;

  // integer multiplier operand extension
  logic [16:0]        ma;
  logic [16:0]        mb;
  logic signed [33:0] mprod;
  logic [31:0]        mul_q;

  // word sign modes; literal and byte modes
  always_comb begin
    ma = {1'b0, opa};
    mb = {1'b0, opb};
    unique case (mul_mode)
      camd_pkg::CAMD_M_SS: begin
        ma = {opa[15], opa};
        mb = {opb[15], opb};
      end
      camd_pkg::CAMD_M_UU: ma = {1'b0, opa};
      camd_pkg::CAMD_M_SU: ma = {opa[15], opa};
      camd_pkg::CAMD_M_US: mb = {opb[15], opb};
      camd_pkg::CAMD_M_SLIT: begin
        ma = {opa[15], opa};
        mb = {12'h000, mul_lit};
      end
      camd_pkg::CAMD_M_ULIT: mb = {12'h000, mul_lit};
      camd_pkg::CAMD_M_BB: begin
        ma = {9'h000, opa[7:0]};
        mb = {9'h000, opb[7:0]};
      end
    endcase
  end
  assign mprod = $signed(ma) * $signed(mb);

  // product register
  always_ff @(posedge ref_clk) begin
    if (reset)
      mul_q <= 32'h00000000;
    else if (mul_valid)
      mul_q <= mprod[31:0];
  end
  assign mul_result = mul_q;

  // divider operands
  logic [3:0]  pair_lo;
  logic [31:0] div_dvd;
  logic [15:0] div_dvs;
  logic        dv_run;
  logic        dv_done;
  logic [15:0] dv_quot;
  logic [15:0] dv_rem;

  // even-aligned pair, high word in odd register
  assign pair_lo = {src_a_sel[3:1], 1'b0};
  assign div_dvs = wreg_q[src_b_sel];
  always_comb begin
    if (div_wide)
      div_dvd = {wreg_q[pair_lo | 4'h1], wreg_q[pair_lo]};
    else
      div_dvd = {{16{div_signed & opa[15]}}, opa};
  end
  // busy covers the write-back cycle too
  assign div_busy = dv_run | dv_done;

  camd_divider u_div (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .start    (div_start && !div_busy),
    .sgn      (div_signed),
    .dividend (div_dvd),
    .divisor  (div_dvs),
    .run      (dv_run),
    .done     (dv_done),
    .quot     (dv_quot),
    .rem      (dv_rem)
  );

  // working register writes; divider results win a collision
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < camd_pkg::WREG_N; i++)
        wreg_q[i] <= camd_pkg::WREG_RST;
    end else if (dv_done) begin
      wreg_q[camd_pkg::QUOT_IDX] <= dv_quot;
      wreg_q[camd_pkg::REM_IDX]  <= dv_rem;
    end else if (mul_valid) begin
      wreg_q[{dst_sel[3:1], 1'b0}] <= mprod[15:0];
      wreg_q[{dst_sel[3:1], 1'b1}] <= mprod[31:16];
    end else if (alu_valid && !dst_to_mem) begin
      // byte writes keep the upper byte
      wreg_q[dst_sel] <= alu_byte ? {wreg_q[dst_sel][15:8], alu_r[7:0]}
                                  : alu_r;
    end
  end
  assign quotient_reg  = wreg_q[camd_pkg::QUOT_IDX];
  assign remainder_reg = wreg_q[camd_pkg::REM_IDX];

  // dsp engine
  logic [39:0]        acc_a_q;
  logic [39:0]        acc_b_q;
  logic [39:0]        acc_t;
  logic [39:0]        acc_o;
  logic [16:0]        ddiff;
  logic [16:0]        dxa;
  logic [16:0]        dxb;
  logic signed [33:0] dprod;
  logic [39:0]        p40;
  logic [40:0]        dsum;
  logic [39:0]        acc_n;
  logic               sat_t;

  assign acc_t = dsp_acc_b ? acc_b_q : acc_a_q;
  assign acc_o = dsp_acc_b ? acc_a_q : acc_b_q;
  assign sat_t = dsp_acc_b ? acc_b_saturate : acc_a_saturate;
  assign ddiff = {dsp_x[15], dsp_x} - {dsp_y[15], dsp_y};

  // dsp operand signedness; mixed is signed x, unsigned y
  always_comb begin
    dxa = (sign_mode_select == camd_pkg::SGN_UU) ? {1'b0, dsp_x}
                                                 : {dsp_x[15], dsp_x};
    dxb = (sign_mode_select == camd_pkg::SGN_SS) ? {dsp_y[15], dsp_y}
                                                 : {1'b0, dsp_y};
    if (dsp_op == camd_pkg::CAMD_SQ || dsp_op == camd_pkg::CAMD_SQAC)
      dxb = dxa;
    if (dsp_op == camd_pkg::CAMD_ED || dsp_op == camd_pkg::CAMD_DIFF_SQUARE_ACCUM_OP) begin
      dxa = ddiff;
      dxb = ddiff;
    end
  end
  // 17x17 product, sign-extended to 40 bits
  assign dprod = $signed(dxa) * $signed(dxb);
  assign p40 = frac_mode_select ? {{5{dprod[33]}}, dprod, 1'b0}
                                : {{6{dprod[33]}}, dprod};

  always_comb begin
    unique case (dsp_op)
      camd_pkg::CAMD_CLR:  dsum = 41'h0;
      camd_pkg::CAMD_ED, camd_pkg::CAMD_SQ, camd_pkg::CAMD_MPY:
        dsum = {p40[39], p40};
      camd_pkg::CAMD_DIFF_SQUARE_ACCUM_OP, camd_pkg::CAMD_MAC, camd_pkg::CAMD_SQAC:
        dsum = {acc_t[39], acc_t} + {p40[39], p40};
      camd_pkg::CAMD_MPYN: dsum = 41'h0 - {p40[39], p40};
      camd_pkg::CAMD_MSC:  dsum = {acc_t[39], acc_t} - {p40[39], p40};
      camd_pkg::CAMD_PREF: dsum = {acc_t[39], acc_t};
      camd_pkg::CAMD_ADDA: dsum = {acc_t[39], acc_t} + {acc_o[39], acc_o};
      camd_pkg::CAMD_SUBA: dsum = {acc_t[39], acc_t} - {acc_o[39], acc_o};
      camd_pkg::CAMD_NEGA: dsum = 41'h0 - {acc_t[39], acc_t};
      // unused op codes give zero rather than a latch
      default:             dsum = 41'h0;
    endcase
  end
  assign acc_n = sat40(dsum, sat_t, saturation_width_select);

  // accumulators; prefetch-only leaves the target untouched
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc_a_q <= camd_pkg::ACC_RST;
      acc_b_q <= camd_pkg::ACC_RST;
    end else if (dsp_valid && dsp_op != camd_pkg::CAMD_PREF) begin
      if (dsp_acc_b)
        acc_b_q <= acc_n;
      else
        acc_a_q <= acc_n;
    end
  end
  assign accumulator_a = acc_a_q;
  assign accumulator_b = acc_b_q;

  // data memory write port; alu has priority over dsp write back
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_we    <= 1'b0;
      mem_byte  <= 1'b0;
      mem_wdata <= 16'h0000;
    end else begin
      mem_we <= 1'b0;
      if (alu_valid && dst_to_mem) begin
        mem_we    <= 1'b1;
        mem_byte  <= alu_byte;
        mem_wdata <= alu_byte ? {8'h00, alu_r[7:0]} : alu_r;
      end else if (dsp_valid && dsp_wb && wb_ok(dsp_op)) begin
        mem_we    <= 1'b1;
        mem_byte  <= 1'b0;
        mem_wdata <= acc_store(acc_o, round_mode_select,
                               memory_write_saturate);
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_div_len;
    div_start && !div_busy |-> ##17 dv_done;
  endproperty
  a_div_len: assert property (p_div_len)
    else $error("divide did not finish in 16 steps");

  property p_div_quot;
    div_start && !div_busy && !div_signed && !div_wide &&
      div_dvs != 16'h0000
      |-> ##18 quotient_reg == $past(opa, 18) / $past(div_dvs, 18);
  endproperty
  a_div_quot: assert property (p_div_quot)
    else $error("quotient not in register 0");

  property p_div_rem;
    div_start && !div_busy && !div_signed && !div_wide &&
      div_dvs != 16'h0000
      |-> ##18 remainder_reg == $past(opa, 18) % $past(div_dvs, 18);
  endproperty
  a_div_rem: assert property (p_div_rem)
    else $error("remainder not in register 1");

  property p_alu_zero;
    alu_valid && !alu_byte |=> status_reg[camd_pkg::ST_Z] ==
      (alu_result == 16'h0000);
  endproperty
  a_alu_zero: assert property (p_alu_zero)
    else $error("zero flag disagrees with result");

  property p_sub_borrow;
    alu_valid && is_sub && !alu_byte
      |=> status_reg[camd_pkg::ST_C] == ($past(opa) >= $past(opb));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("borrow flag wrong after subtract");

  property p_mul_uu;
    mul_valid && mul_mode == camd_pkg::CAMD_M_UU
      |=> mul_result == $past(opa) * $past(opb);
  endproperty
  a_mul_uu: assert property (p_mul_uu)
    else $error("unsigned product wrong");

  property p_mul_bb;
    mul_valid && mul_mode == camd_pkg::CAMD_M_BB
      |=> mul_result[31:16] == 16'h0000;
  endproperty
  a_mul_bb: assert property (p_mul_bb)
    else $error("byte product exceeds 16 bits");

  property p_acc_clr;
    dsp_valid && dsp_op == camd_pkg::CAMD_CLR && !dsp_acc_b
      |=> accumulator_a == camd_pkg::ACC_RST;
  endproperty
  a_acc_clr: assert property (p_acc_clr)
    else $error("clear left accumulator non-zero");

  property p_sat_a;
    dsp_valid && !dsp_acc_b && acc_a_saturate && !saturation_width_select
      |=> accumulator_a[39:31] == {9{accumulator_a[39]}};
  endproperty
  a_sat_a: assert property (p_sat_a)
    else $error("accumulator a beyond saturation range");

  property p_no_wb;
    dsp_valid && !wb_ok(dsp_op) && !alu_valid |=> !mem_we;
  endproperty
  a_no_wb: assert property (p_no_wb)
    else $error("write back from op that forbids it");

  c_div_done: cover property (dv_done);
  c_dsp_wb: cover property (dsp_valid && dsp_wb && wb_ok(dsp_op));
  c_sat_hit: cover property (dsp_valid && sat_t && acc_n != dsum[39:0]);
  c_byte_sub: cover property (alu_valid && alu_byte && is_sub);
endmodule

// >>> verilog/camd_divider.sv
// iterative restoring divider, 16 steps, signed or unsigned
`timescale 1ns/1ps
module camd_divider (
  // clock and reset
  input  logic        ref_clk,
  input  logic        reset,
  // request
  input  logic        start,
  input  logic        sgn,
  input  logic [31:0] dividend,
  input  logic [15:0] divisor,
  // answer
  output logic        run,
  output logic        done,
  output logic [15:0] quot,
  output logic [15:0] rem
);
  typedef enum logic {CAMD_DV_IDLE, CAMD_DV_RUN} camd_div_state_e;

  camd_div_state_e state_q;  // idle or iterating
  logic [4:0]  cnt_q;        // step counter
  logic [15:0] rem_q;        // partial remainder
  logic [15:0] sh_q;         // dividend low bits, then quotient
  logic [15:0] dvs_q;        // divisor magnitude
  logic        nq_q;         // negate quotient at end
  logic        nr_q;         // negate remainder at end
  logic [31:0] dvd_mag;
  logic [16:0] trial;
  logic        qb;
  logic [15:0] rem_n;
  logic [15:0] sh_n;

  // magnitude of dividend for signed requests
  assign dvd_mag = (sgn && dividend[31]) ? (32'h0 - dividend) : dividend;
  // one trial subtraction per step
  assign trial = {rem_q, sh_q[15]} - {1'b0, dvs_q};
  assign qb    = !trial[16];
  assign rem_n = qb ? trial[15:0] : {rem_q[14:0], sh_q[15]};
  assign sh_n  = {sh_q[14:0], qb};
  assign run   = (state_q == CAMD_DV_RUN);

  // sequence and datapath; quotient overflow is not detected
  always_ff @(posedge ref_clk) begin
    done <= 1'b0;
    if (reset) begin
      state_q <= CAMD_DV_IDLE;
      cnt_q   <= 5'h00;
      rem_q   <= 16'h0000;
      sh_q    <= 16'h0000;
      dvs_q   <= 16'h0000;
      nq_q    <= 1'b0;
      nr_q    <= 1'b0;
      quot    <= 16'h0000;
      rem     <= 16'h0000;
    end else begin
      unique case (state_q)
        CAMD_DV_IDLE: begin
          if (start) begin
            state_q <= CAMD_DV_RUN;
            cnt_q   <= 5'h00;
            rem_q   <= dvd_mag[31:16];
            sh_q    <= dvd_mag[15:0];
            dvs_q   <= (sgn && divisor[15]) ? (16'h0 - divisor) : divisor;
            nq_q    <= sgn && (dividend[31] ^ divisor[15]);
            nr_q    <= sgn && dividend[31];
          end
        end
        CAMD_DV_RUN: begin
          rem_q <= rem_n;
          sh_q  <= sh_n;
          cnt_q <= cnt_q + 5'h01;
          // last step: sign fix and hand over
          if (cnt_q == camd_pkg::DIV_LAST) begin
            state_q <= CAMD_DV_IDLE;
            done    <= 1'b1;
            quot    <= nq_q ? (16'h0 - sh_n) : sh_n;
            rem     <= nr_q ? (16'h0 - rem_n) : rem_n;
          end
        end
      endcase
    end
  end
endmodule

// >>> verilog/camd_pkg.sv
// shared constants and types for the arithmetic datapath
package camd_pkg;
  // status register bit positions
  localparam int unsigned ST_C  = 0;
  localparam int unsigned ST_Z  = 1;
  localparam int unsigned ST_OV = 2;
  localparam int unsigned ST_N  = 3;
  localparam int unsigned ST_DC = 4;
  localparam logic [4:0] STATUS_RST = 5'h00;
  // working register array
  localparam int unsigned WREG_N = 16;
  localparam logic [15:0] WREG_RST = 16'h0000;
  localparam logic [3:0]  QUOT_IDX = 4'h0;
  localparam logic [3:0]  REM_IDX  = 4'h1;
  // divider iterations, one per divisor bit
  localparam logic [4:0] DIV_LAST = 5'h0F;
  // accumulator reset and clamp values
  localparam logic [39:0] ACC_RST   = 40'h0000000000;
  localparam logic [39:0] SAT31_POS = 40'h007FFFFFFF;
  localparam logic [39:0] SAT31_NEG = 40'hFF80000000;
  localparam logic [39:0] SAT39_POS = 40'h7FFFFFFFFF;
  localparam logic [39:0] SAT39_NEG = 40'h8000000000;
  localparam logic [39:0] RND_HALF  = 40'h0000008000;
  localparam logic [15:0] MEM_POS   = 16'h7FFF;
  localparam logic [15:0] MEM_NEG   = 16'h8000;
  // dsp sign mode codes
  localparam logic [1:0] SGN_SS  = 2'h0;
  localparam logic [1:0] SGN_UU  = 2'h1;
  localparam logic [1:0] SGN_MIX = 2'h2;
  // alu operations
  typedef enum logic [2:0] {
    CAMD_ADD, CAMD_SUB, CAMD_AND, CAMD_IOR,
    CAMD_XOR, CAMD_SHL, CAMD_LSR, CAMD_ASR
  } camd_alu_op_e;
  // integer multiply operand modes
  typedef enum logic [2:0] {
    CAMD_M_SS, CAMD_M_UU, CAMD_M_SU, CAMD_M_US,
    CAMD_M_SLIT, CAMD_M_ULIT, CAMD_M_BB
  } camd_mul_mode_e;
  // dsp operations
  typedef enum logic [3:0] {
    CAMD_CLR, CAMD_ED, CAMD_DIFF_SQUARE_ACCUM_OP, CAMD_MAC, CAMD_SQAC,
    CAMD_MPY, CAMD_SQ, CAMD_MPYN, CAMD_MSC, CAMD_PREF,
    CAMD_ADDA, CAMD_SUBA, CAMD_NEGA
  } camd_dsp_op_e;
endpackage
